// >>> hdl/diag_event_pkg.sv
package diag_event_pkg;

  // ****************************************
  // sizes
  // ****************************************
  localparam int NUM_EVT = 17;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] OFS_MASK = 8'h00;
  localparam logic [7:0] OFS_FUNC = 8'h04;
  localparam logic [7:0] OFS_LOWER = 8'h08;
  localparam logic [7:0] OFS_UPPER = 8'h0C;
  localparam logic [7:0] OFS_ACTIVE = 8'h10;
  localparam logic [7:0] OFS_REPORTED = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [15:0] MASK_RST = 16'hFFFF;
  localparam logic [7:0] FUNC_RST = 8'h00;
  localparam logic [15:0] LOWER_RST = 16'h0000;
  localparam logic [15:0] UPPER_RST = 16'h6C00;

  // ****************************************
  // channel function codes
  // ****************************************
  localparam logic [7:0] FN_IN_U_UNI = 8'h01;
  localparam logic [7:0] FN_IN_U_BIP = 8'h02;
  localparam logic [7:0] FN_IN_I_4_20 = 8'h04;
  localparam logic [7:0] FN_OUT_U_UNI = 8'h06;
  localparam logic [7:0] FN_OUT_U_BIP = 8'h07;
  localparam logic [7:0] FN_OUT_I_0_20 = 8'h08;
  localparam logic [7:0] FN_OUT_I_4_20 = 8'h09;

  // ****************************************
  // process value range limits
  // ****************************************
  localparam logic signed [15:0] NOM_HIGH = 16'sh6C00;
  localparam logic signed [15:0] NOM_LOW_BIP = -16'sh6C00;
  localparam logic signed [15:0] NOM_LOW_UNI = 16'sh0000;

  // ****************************************
  // event type and device status values
  // ****************************************
  localparam logic [1:0] TYPE_NOTIF = 2'h1;
  localparam logic [1:0] TYPE_WARN = 2'h2;
  localparam logic [1:0] TYPE_ERR = 2'h3;
  localparam logic [2:0] DSTAT_OK = 3'h0;
  localparam logic [2:0] DSTAT_WARN = 3'h2;
  localparam logic [2:0] DSTAT_ERR = 3'h4;
  localparam logic [15:0] CODE_NONE = 16'h0000;

  // ****************************************
  // event table, index 0 has top priority
  // ****************************************
  localparam logic [15:0] EVT_CODE [NUM_EVT] = '{
    16'h4210, 16'h5110, 16'h5111, 16'h6320, 16'h7700, 16'h8C10,
    16'h8C30, 16'h1800, 16'h1801, 16'h1802, 16'h1803, 16'h1804,
    16'h1805, 16'h1806, 16'h1809, 16'h180A, 16'h180B};
  // 1 marks an error, 0 a warning
  localparam logic [NUM_EVT-1:0] EVT_IS_ERR = 17'h1C998;
  // 0 marks events the mask never suppresses
  localparam logic [NUM_EVT-1:0] EVT_MASKABLE = 17'h1FE77;
  localparam logic [3:0] EVT_MASK_BIT [NUM_EVT] = '{
    4'h3, 4'h4, 4'h5, 4'h0, 4'hA, 4'hF, 4'hE, 4'h0, 4'h0,
    4'h1, 4'h2, 4'hB, 4'hF, 4'hE, 4'h7, 4'h6, 4'h6};

endpackage

// >>> hdl/diagnostic_event_mapper.sv
`timescale 1ns/10ps
// Function
// - events limited to variant and channel function
// - overtemperature: 0x4210 warning, mask bit 3
// - supply overvoltage: 0x5110 warning, mask bit 4
// - supply undervoltage: 0x5111 warning, mask bit 5
// - parameter out of range: 0x6320 error
// - current output cable break: 0x7700, bit 10
// - output value overdrive: 0x8C10, bit 15
// - output value underdrive: 0x8C30, bit 14
// - production data invalid: 0x1800, never masked
// - parameter data invalid: 0x1801, never masked
// - below lower threshold: 0x1802, bit 1
// - above upper threshold: 0x1803, bit 2
// - sensor supply overcurrent: 0x1804, bit 11
// - input overdrive: 0x1805, bit 15
// - input underdrive: 0x1806, bit 14
// - output voltage too high: 0x1809, bit 7
// - output voltage too low: 0x180A, bit 6
// - rev 1 output overdrive: 0x180B, bit 6
// - mask meaning follows selected channel function
// - thresholds watch output or input data
module diagnostic_event_mapper
  import diag_event_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // variant straps
  input wire logic output_variant,
  input wire logic variant_multi,
  input wire logic hw_rev_one,
  input wire logic [7:0] fixed_function,
  // raw fault levels from the analog side
  input wire logic over_temp,
  input wire logic supply_over,
  input wire logic supply_under,
  input wire logic param_range_fault,
  input wire logic cable_break,
  input wire logic prod_data_bad,
  input wire logic param_data_bad,
  input wire logic sensor_overcurrent,
  input wire logic vout_high,
  input wire logic vout_low,
  input wire logic vout_overdrive,
  // process values
  input wire logic [15:0] output_process_value,
  input wire logic [15:0] measured_input_value,
  // event port toward the link layer
  input wire logic evt_ack,
  output logic evt_valid,
  output logic [15:0] evt_code,
  output logic [2:0] evt_status,
  output logic [1:0] evt_type,
  output logic evt_appear,
  // summary
  output logic [2:0] device_status,
  output logic [15:0] active_code
);

  // ****************************************
  // software registers
  // ****************************************
  logic [15:0] diagnosis_event_mask;   // enable per mask bit
  logic [7:0] func_reg;                // written channel function
  logic signed [15:0] lower_alert_threshold;  // signed, process scaling
  logic signed [15:0] upper_alert_threshold;  // signed, process scaling

  // ****************************************
  // event state
  // ****************************************
  logic [NUM_EVT-1:0] raw_cond;   // applicable fault levels
  logic [NUM_EVT-1:0] gated_cond; // after the mask
  logic [NUM_EVT-1:0] req;        // slot wants a report
  logic [NUM_EVT-1:0] reported;   // appearing reported
  logic [NUM_EVT-1:0] grant;      // one-hot acknowledge

  // ****************************************
  // channel function decode
  // ****************************************
  logic [7:0] channel_function_select; // function in force
  logic [7:0] default_function;        // multi variant default
  logic is_in;                         // valid input function
  logic is_out;                        // valid output function
  logic volt_out;                      // voltage output function
  logic cur_out;                       // current output function
  logic fn_valid;                      // function fits the variant

  // a zero register means never written: take the variant default
  assign default_function = output_variant ? FN_OUT_U_UNI : FN_IN_U_UNI;
  // fixed variants ignore the register entirely
  assign channel_function_select = !variant_multi ? fixed_function :
    (func_reg == FUNC_RST) ? default_function : func_reg;

  // input functions only count on input hardware and the reverse
  assign is_in = !output_variant &&
    (channel_function_select >= FN_IN_U_UNI) &&
    (channel_function_select <= FN_IN_I_4_20);
  assign is_out = output_variant &&
    (channel_function_select >= FN_OUT_U_UNI) &&
    (channel_function_select <= FN_OUT_I_4_20);
  assign volt_out = is_out && (channel_function_select <= FN_OUT_U_BIP);
  assign cur_out = is_out && (channel_function_select >= FN_OUT_I_0_20);
  assign fn_valid = is_in || is_out;

  // ****************************************
  // process value comparisons
  // ****************************************
  logic signed [15:0] opv;      // value received from master
  logic signed [15:0] miv;      // value sent to master
  logic signed [15:0] mon;      // value under threshold watch
  logic signed [15:0] out_low;  // output nominal floor
  logic signed [15:0] in_low;   // input nominal floor
  assign opv = output_process_value;
  assign miv = measured_input_value;
  // thresholds follow the data direction of the variant
  assign mon = output_variant ? opv : miv;
  // bipolar ranges go down to minus full scale
  assign out_low = (channel_function_select == FN_OUT_U_BIP) ?
    NOM_LOW_BIP : NOM_LOW_UNI;
  assign in_low = (channel_function_select == FN_IN_U_BIP) ?
    NOM_LOW_BIP : NOM_LOW_UNI;

  // ****************************************
  // raw conditions, filtered by applicability
  // ****************************************
  assign raw_cond[0] = over_temp;
  assign raw_cond[1] = supply_over;
  assign raw_cond[2] = supply_under;
  // a function code foreign to the variant is a parameter error too
  assign raw_cond[3] = param_range_fault || !fn_valid;
  assign raw_cond[4] = cable_break && cur_out;
  assign raw_cond[5] = is_out && (opv > NOM_HIGH);
  assign raw_cond[6] = is_out && (opv < out_low);
  assign raw_cond[7] = prod_data_bad;
  assign raw_cond[8] = param_data_bad;
  assign raw_cond[9] = fn_valid && (mon < lower_alert_threshold);
  assign raw_cond[10] = fn_valid && (mon > upper_alert_threshold);
  assign raw_cond[11] = sensor_overcurrent;
  assign raw_cond[12] = is_in && (miv > NOM_HIGH);
  assign raw_cond[13] = is_in && (miv < in_low);
  assign raw_cond[14] = vout_high && volt_out;
  assign raw_cond[15] = vout_low && volt_out;
  assign raw_cond[16] = vout_overdrive && volt_out && hw_rev_one;

  // ****************************************
  // mask gating and per-event slots
  // ****************************************
  // the mask bit number is fixed per event; the bit's meaning changes
  // with the function only through the applicability terms above
  genvar gi;
  generate
    for (gi = 0; gi < NUM_EVT; gi++) begin : g_evt
      // unmaskable events bypass the mask altogether
      assign gated_cond[gi] = raw_cond[gi] &&
        (!EVT_MASKABLE[gi] ||
         diagnosis_event_mask[EVT_MASK_BIT[gi]]);
      event_slot u_slot (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .cond(gated_cond[gi]),
        .grant(grant[gi]),
        .grant_appear(evt_appear),
        .req(req[gi]),
        .reported(reported[gi])
      );
    end
  endgenerate

  // ****************************************
  // priority pick
  // ****************************************
  logic [4:0] pick_idx;      // lowest pending index
  logic pick_any;            // something pending
  logic [4:0] cur_idx;       // index on the event port
  logic [4:0] top_idx;       // lowest reported index
  logic top_any;             // any event reported
  logic [2:0] worst_status;  // highest status of reported events
  // low index wins; scan from the top so the last hit is lowest
  always_comb begin
    pick_idx = 5'h00;
    pick_any = 1'b0;
    for (int i = NUM_EVT - 1; i >= 0; i--) begin
      if (req[i]) begin
        pick_idx = 5'(i);
        pick_any = 1'b1;
      end
    end
  end

  // summary view of what the master currently believes
  always_comb begin
    top_idx = 5'h00;
    top_any = 1'b0;
    worst_status = DSTAT_OK;
    for (int i = NUM_EVT - 1; i >= 0; i--) begin
      if (reported[i]) begin
        top_idx = 5'(i);
        top_any = 1'b1;
        if (EVT_IS_ERR[i]) begin
          worst_status = DSTAT_ERR;
        end else if (worst_status == DSTAT_OK) begin
          worst_status = DSTAT_WARN;
        end
      end
    end
  end

  // ****************************************
  // event port sequencer
  // ****************************************
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_PRESENT
  } evt_state_e;
  evt_state_e state;       // current state
  evt_state_e next_state;  // next state
  logic take;              // load a new event this cycle
  logic done;              // master acknowledged
  assign take = (state == ST_IDLE) && pick_any;
  assign done = (state == ST_PRESENT) && evt_ack;

  // ack lands on the slot shown, which then records the qualifier
  assign grant = done ? (NUM_EVT'(1) << cur_idx) : '0;

  // state transitions
  always_comb begin
    case (state)
      ST_IDLE: begin
        next_state = pick_any ? ST_PRESENT : ST_IDLE;
      end
      ST_PRESENT: begin
        next_state = evt_ack ? ST_IDLE : ST_PRESENT;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // event port outputs
  // ****************************************
  logic pick_err;  // picked event is an error
  assign pick_err = EVT_IS_ERR[pick_idx];

  // fields freeze while shown; a condition flipping back meanwhile is
  // simply reported as a second event after the ack
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evt_valid <= 1'b0;
      cur_idx <= 5'h00;
      evt_code <= CODE_NONE;
      evt_status <= DSTAT_OK;
      evt_type <= TYPE_NOTIF;
      evt_appear <= 1'b0;
    end else if (take) begin
      evt_valid <= 1'b1;
      cur_idx <= pick_idx;
      evt_code <= EVT_CODE[pick_idx];
      evt_status <= pick_err ? DSTAT_ERR : DSTAT_WARN;
      evt_type <= pick_err ? TYPE_ERR : TYPE_WARN;
      // appearing when the live level is set, else disappearing
      evt_appear <= gated_cond[pick_idx];
    end else if (done) begin
      // idle port shows the no-malfunction notification
      evt_valid <= 1'b0;
      evt_code <= CODE_NONE;
      evt_status <= DSTAT_OK;
      evt_type <= TYPE_NOTIF;
      evt_appear <= 1'b0;
    end
  end

  // ****************************************
  // summary outputs
  // ****************************************
  // the external status index 0x45 mirror is served elsewhere; these
  // levels feed it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      device_status <= DSTAT_OK;
      active_code <= CODE_NONE;
    end else begin
      device_status <= worst_status;
      active_code <= top_any ? EVT_CODE[top_idx] : CODE_NONE;
    end
  end

  // ****************************************
  // register write decode
  // ****************************************
  logic wr_mask;   // write to mask
  logic wr_func;   // write to channel function
  logic wr_lower;  // write to lower threshold
  logic wr_upper;  // write to upper threshold
  assign wr_mask = wr && (addr == OFS_MASK);
  // fixed variants accept the write but keep their function
  assign wr_func = wr && (addr == OFS_FUNC) && variant_multi;
  assign wr_lower = wr && (addr == OFS_LOWER);
  assign wr_upper = wr && (addr == OFS_UPPER);

  // writable registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      diagnosis_event_mask <= MASK_RST;
      func_reg <= FUNC_RST;
      lower_alert_threshold <= LOWER_RST;
      upper_alert_threshold <= UPPER_RST;
    end else begin
      if (wr_mask) begin
        diagnosis_event_mask <= wdata[15:0];
      end
      // any code is stored; a foreign one raises the parameter error
      if (wr_func) begin
        func_reg <= wdata[7:0];
      end
      if (wr_lower) begin
        lower_alert_threshold <= wdata[15:0];
      end
      if (wr_upper) begin
        upper_alert_threshold <= wdata[15:0];
      end
    end
  end

  // ****************************************
  // register read mux
  // ****************************************
  logic [31:0] rd_mux;  // selected read word
  // unmapped offsets read zero; upper bits read zero
  assign rd_mux =
    (addr == OFS_MASK) ? {16'h0000, diagnosis_event_mask} :
    (addr == OFS_FUNC) ? {24'h000000, channel_function_select} :
    (addr == OFS_LOWER) ? {16'h0000, lower_alert_threshold} :
    (addr == OFS_UPPER) ? {16'h0000, upper_alert_threshold} :
    (addr == OFS_ACTIVE) ? {15'h0000, gated_cond} :
    (addr == OFS_REPORTED) ? {15'h0000, reported} :
    (addr == OFS_STATUS) ? {13'h0000, device_status, active_code} :
    32'h00000000;

  // data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd ? rd_mux : 32'h00000000;
    end
  end

endmodule

// >>> hdl/event_slot.sv
`timescale 1ns/10ps
// one event: remembers whether its appearance was reported
module event_slot (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic cond,          // gated fault condition
  input wire logic grant,         // master took this event
  input wire logic grant_appear,  // qualifier that was taken
  output logic req,               // report pending
  output logic reported           // appearance reported, not yet cleared
);

  // ****************************************
  // report state
  // ****************************************
  // pending whenever the live level differs from what the master knows
  assign req = cond ^ reported;

  // update only on acknowledge, so a lost ack never loses an edge
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reported <= 1'b0;
    end else if (grant) begin
      reported <= grant_appear;
    end
  end

endmodule

// >>> testbench/diag_event_props.sv
`timescale 1ns/10ps
// ********
// event port checks
// ********
module diag_event_props (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic output_variant,
  input wire logic over_temp,
  input wire logic [15:0] measured_input_value,
  input wire logic evt_ack,
  input wire logic evt_valid,
  input wire logic [15:0] evt_code,
  input wire logic [2:0] evt_status,
  input wire logic [1:0] evt_type,
  input wire logic evt_appear
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  chk_idle_notify: assert property (!evt_valid |->
    evt_code == 16'h0000 && evt_status == 3'h0 && evt_type == 2'h1 && !evt_appear)
    else $error("idle event fields wrong");
  chk_hold_fields: assert property (evt_valid && !evt_ack |=>
    evt_valid && $stable(evt_code) && $stable(evt_appear) && $stable(evt_status))
    else $error("event dropped or changed before ack");
  chk_ack_release: assert property (evt_valid && evt_ack |=> !evt_valid)
    else $error("event still shown after ack");
  chk_error_codes: assert property (evt_valid && evt_code inside {16'h6320,
    16'h7700, 16'h1800, 16'h1801, 16'h1804, 16'h1809, 16'h180A, 16'h180B}
    |-> evt_status == 3'h4 && evt_type == 2'h3) else $error("error event status wrong");
  chk_warn_codes: assert property (evt_valid && evt_code inside {16'h4210,
    16'h5110, 16'h5111, 16'h8C10, 16'h8C30, 16'h1802, 16'h1803, 16'h1805, 16'h1806}
    |-> evt_status == 3'h2 && evt_type == 2'h2) else $error("warning event status wrong");
  chk_input_scope: assert property (evt_valid && !output_variant |-> !(evt_code
    inside {16'h7700, 16'h8C10, 16'h8C30, 16'h1809, 16'h180A, 16'h180B}))
    else $error("output event on input hardware");
  chk_output_scope: assert property (evt_valid && output_variant |->
    !(evt_code inside {16'h1805, 16'h1806})) else $error("input event on output hardware");
  chk_overtemp_cause: assert property ($rose(evt_valid) && evt_code == 16'h4210
    && evt_appear |-> $past(over_temp)) else $error("overtemperature shown without cause");
  chk_overdrive_cause: assert property ($rose(evt_valid) && evt_code == 16'h1805
    && evt_appear |-> $signed($past(measured_input_value)) > 16'sh6C00)
    else $error("input overdrive shown in range");

  cover property ($rose(evt_valid) && evt_appear);
  cover property (evt_valid && evt_ack && !evt_appear);
  cover property (evt_valid && evt_code == 16'h180B);
endmodule

bind diagnostic_event_mapper diag_event_props u_props (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .output_variant(output_variant),
  .over_temp(over_temp),
  .measured_input_value(measured_input_value),
  .evt_ack(evt_ack),
  .evt_valid(evt_valid),
  .evt_code(evt_code),
  .evt_status(evt_status),
  .evt_type(evt_type),
  .evt_appear(evt_appear)
);

// >>> testbench/event_taker.sv
`timescale 1ns/10ps
// ********
// link-side taker of events
// ********
// index 0x45 readout is beyond this port
module event_taker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic evt_valid,
  input wire logic [15:0] evt_code,
  input wire logic [2:0] evt_status,
  input wire logic [1:0] evt_type,
  input wire logic evt_appear,
  input wire logic [3:0] ack_delay,  // cycles to dawdle before ack
  output logic evt_ack,
  output logic [7:0] taken_cnt,      // events taken so far
  output logic [21:0] taken          // last event taken
);
  logic [3:0] wait_cnt;
  // ack is one cycle; fields are logged at the edge that takes it
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      evt_ack <= 1'b0;
      wait_cnt <= 4'h0;
      taken_cnt <= 8'h00;
      taken <= '0;
    end else if (evt_ack) begin
      evt_ack <= 1'b0;
      taken <= {evt_code, evt_status, evt_type, evt_appear};
      taken_cnt <= taken_cnt + 8'h01;
    end else if (evt_valid && wait_cnt == ack_delay) begin
      evt_ack <= 1'b1;
      wait_cnt <= 4'h0;
    end else if (evt_valid) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule

// >>> testbench/test_diagnostic_event_mapper.sv
`timescale 1ns/10ps
module test_diagnostic_event_mapper import diag_event_pkg::*; ;
  logic ref_clk, rstn, wr, rd, out_var, hw1, evt_ack, evt_valid, evt_appear;
  logic [7:0] addr, taken_cnt;
  logic [31:0] wdata, rdata;
  logic [10:0] flt;  // fault levels, one bit per input
  logic [15:0] opv, miv, evt_code, active_code;
  logic [3:0] ack_delay;
  logic [2:0] evt_status, device_status;
  logic [1:0] evt_type;
  logic [21:0] taken;
  int failures, check_count;
  // fault bit, code and error flag of the always-present events
  localparam int FB [7] = '{0, 1, 2, 3, 5, 6, 7};
  localparam logic [15:0] FC [7] = '{16'h4210, 16'h5110, 16'h5111, 16'h6320,
    16'h1800, 16'h1801, 16'h1804};
  localparam logic [6:0] FE = 7'h78;
  localparam logic [15:0] FO [3] = '{16'h1809, 16'h180A, 16'h180B};

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  diagnostic_event_mapper uut (.ref_clk(ref_clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .output_variant(out_var), .variant_multi(1'b1),
    .hw_rev_one(hw1), .fixed_function(8'h01), .over_temp(flt[0]), .supply_over(flt[1]),
    .supply_under(flt[2]), .param_range_fault(flt[3]), .cable_break(flt[4]),
    .prod_data_bad(flt[5]), .param_data_bad(flt[6]), .sensor_overcurrent(flt[7]),
    .vout_high(flt[8]), .vout_low(flt[9]), .vout_overdrive(flt[10]),
    .output_process_value(opv), .measured_input_value(miv), .evt_ack(evt_ack),
    .evt_valid(evt_valid), .evt_code(evt_code), .evt_status(evt_status),
    .evt_type(evt_type), .evt_appear(evt_appear), .device_status(device_status),
    .active_code(active_code));

  event_taker taker (.ref_clk(ref_clk), .rstn(rstn), .evt_valid(evt_valid),
    .evt_code(evt_code), .evt_status(evt_status), .evt_type(evt_type),
    .evt_appear(evt_appear), .ack_delay(ack_delay), .evt_ack(evt_ack),
    .taken_cnt(taken_cnt), .taken(taken));

  // ********
  // helpers
  // ********
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task do_reset;
    rstn <= 1'b0;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
  endtask

  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask

  task set_flt(input int i, input logic v);
    @(posedge ref_clk);
    flt[i] <= v;
  endtask

  task set_pv(input logic sel, input logic [15:0] v);
    @(posedge ref_clk);
    if (sel) opv <= v;
    else miv <= v;
  endtask

  // waits, bounded, for the taker to log one more event
  task get_evt(input logic [15:0] c, input logic e, input logic a);
    logic [7:0] n;
    int k;
    n = taken_cnt;
    k = 0;
    while (taken_cnt === n && k < 200) begin
      @(posedge ref_clk);
      #1 k++;
    end
    chk({24'h0, 8'(taken_cnt - n)}, 32'h1);
    chk({10'h0, taken}, {10'h0, c, e ? 3'h4 : 3'h2, e ? 2'h3 : 2'h2, a});
  endtask

  task no_evt;
    logic [7:0] n;
    n = taken_cnt;
    repeat (12) @(posedge ref_clk);
    #1 chk({24'h0, taken_cnt}, {24'h0, n});
  endtask

  // raise one fault, see it appear and summarised, drop it, see it go
  task pulse(input int i, input logic [15:0] c, input logic e);
    set_flt(i, 1'b1);
    get_evt(c, e, 1'b1);
    repeat (3) @(posedge ref_clk);
    #1 chk({29'h0, device_status}, {29'h0, e ? 3'h4 : 3'h2});
    chk({16'h0, active_code}, {16'h0, c});
    rd_chk(OFS_STATUS, {13'h0, e ? 3'h4 : 3'h2, c});
    set_flt(i, 1'b0);
    get_evt(c, e, 1'b0);
  endtask

  // ********
  // watchdog, far beyond the expected run
  // ********
  initial begin
    repeat (20000) @(posedge ref_clk);
    failures++;
    final_report;
  end

  // ********
  // tests
  // ********
  initial begin
    {rstn, wr, rd, out_var, hw1, flt, addr, wdata} = '0;
    opv = 16'h1000;
    miv = 16'h0200;
    ack_delay = 4'h0;
    failures = 0;
    check_count = 0;
    do_reset;
    #1 chk({evt_valid, evt_code, evt_status, evt_type, evt_appear, 9'h0}, 32'h00000400);
    rd_chk(OFS_MASK, {16'h0, MASK_RST});
    rd_chk(OFS_FUNC, 32'h01);
    rd_chk(OFS_LOWER, 32'h0);
    rd_chk(OFS_UPPER, {16'h0, UPPER_RST});
    rd_chk(8'h1C, 32'h0);
    for (int i = 0; i < 7; i++) pulse(FB[i], FC[i], FE[i]);
    // masking holds back, unmasking reveals, masking retracts
    wr_reg(OFS_MASK, 32'hFFF7);
    set_flt(0, 1'b1);
    no_evt;
    wr_reg(OFS_MASK, 32'hFFFF);
    get_evt(16'h4210, 1'b0, 1'b1);
    wr_reg(OFS_MASK, 32'hFFF7);
    get_evt(16'h4210, 1'b0, 1'b0);
    set_flt(0, 1'b0);
    no_evt;
    wr_reg(OFS_MASK, 32'h0);
    pulse(5, 16'h1800, 1'b1);
    wr_reg(OFS_MASK, 32'hFFFF);
    // output-only faults stay silent on input hardware
    set_flt(4, 1'b1);
    set_flt(8, 1'b1);
    no_evt;
    set_flt(4, 1'b0);
    set_flt(8, 1'b0);
    // thresholds and range on the measured value
    wr_reg(OFS_LOWER, 32'h0100);
    set_pv(1'b0, 16'h0050);
    get_evt(16'h1802, 1'b0, 1'b1);
    set_pv(1'b0, 16'h7000);
    get_evt(16'h1802, 1'b0, 1'b0);
    get_evt(16'h1803, 1'b0, 1'b1);
    get_evt(16'h1805, 1'b0, 1'b1);
    set_pv(1'b0, 16'hFF00);
    get_evt(16'h1802, 1'b0, 1'b1);
    get_evt(16'h1803, 1'b0, 1'b0);
    get_evt(16'h1805, 1'b0, 1'b0);
    get_evt(16'h1806, 1'b0, 1'b1);
    set_pv(1'b0, 16'h0200);
    get_evt(16'h1802, 1'b0, 0);
    get_evt(16'h1806, 1'b0, 1'b0);
    // output hardware, revision one, slow taker
    @(posedge ref_clk);
    out_var <= 1'b1;
    hw1 <= 1'b1;
    ack_delay <= 4'h4;
    do_reset;
    rd_chk(OFS_FUNC, 32'h06);
    for (int i = 8; i < 11; i++) pulse(i, FO[i-8], 1'b1);
    set_pv(1'b1, 16'h7000);
    get_evt(16'h8C10, 1'b0, 1'b1);
    get_evt(16'h1803, 1'b0, 1'b1);
    set_pv(1'b1, 16'hFFFF);
    get_evt(16'h8C10, 1'b0, 1'b0);
    get_evt(16'h8C30, 1'b0, 1'b1);
    get_evt(16'h1802, 1'b0, 1'b1);
    get_evt(16'h1803, 1'b0, 1'b0);
    set_pv(1'b1, 16'h1000);
    get_evt(16'h8C30, 1'b0, 1'b0);
    get_evt(16'h1802, 1'b0, 1'b0);
    // current output: voltage checks off, cable break on
    wr_reg(OFS_FUNC, 32'h08);
    rd_chk(OFS_FUNC, 32'h08);
    set_flt(8, 1'b1);
    no_evt;
    set_flt(8, 1'b0);
    pulse(4, 16'h7700, 1'b1);
    wr_reg(OFS_FUNC, 32'h05);
    get_evt(16'h6320, 1'b1, 1'b1);
    wr_reg(OFS_FUNC, 32'h09);
    get_evt(16'h6320, 1'b1, 1'b0);
    final_report;
  end
endmodule
